// ===== regbank_pkg.sv
// Purpose: Shared constants for the DAC control register bank
// Assumes: Program words are 16 bits, address in [15:9], data in [8:0]
// Notes: Both design files use the word width; reset values and field positions are used by the register bank
package regbank_pkg;
	localparam int WORD_BITS = 16;
	localparam int ADDR_HI = 15;
	localparam int ADDR_LO = 9;
	localparam int DATA_HI = 8;
	localparam logic [6:0] ADDR_LEFT_VOLUME = 7'h00;
	localparam logic [6:0] ADDR_RIGHT_VOLUME = 7'h01;
	localparam logic [6:0] ADDR_CONVERTER_CTRL = 7'h02;
	localparam logic [6:0] ADDR_INTERFACE_CTRL = 7'h03;
	// Volume word fields
	localparam int BIT_APPLY_STROBE = 8;
	localparam logic [7:0] ATTEN_RESET = 8'hff;
	localparam logic [7:0] ATTEN_CODE_MUTE = 8'h00;
	localparam logic [7:0] ATTEN_CODE_TOP = 8'hff;
	// Converter control word fields
	localparam int BIT_SOFT_SILENCE = 0;
	localparam int BIT_EMPHASIS = 1;
	localparam int BIT_LOW_POWER = 2;
	localparam int FORMAT_LO = 3;
	localparam int FORMAT_HI = 5;
	// Interface control word fields
	localparam int BIT_FORMAT_I2S = 0;
	localparam int BIT_FRAME_POLARITY = 1;
	localparam int BIT_RIGHT_FOLLOWS = 2;
	localparam int BIT_PHASE_INVERT = 4;
	localparam int BIT_BIT_CLOCK_INVERT = 5;
	localparam int BIT_ZERO_DETECT = 8;
	localparam logic [2:0] FORMAT_FIELD_RESET = 3'h0;
	localparam logic CTRL_BIT_RESET = 1'b0;
	// Sample counts
	localparam logic [4:0] IGNORE_SAMPLES = 5'h10;
	localparam logic [10:0] ZERO_RUN_SAMPLES = 11'h400;
	// Audio input format kinds
	typedef enum logic [1:0] {
		FMT_RIGHT_JUSTIFIED,
		FMT_LEFT_JUSTIFIED,
		FMT_I2S,
		FMT_DSP
	} format_kind_e;
endpackage : regbank_pkg

// ===== serial_word_shifter.sv
// Purpose: Collects one 16-bit program word from the serial control pins
// Assumes: Pin inputs are synchronous to clk and much slower than it
// Notes: Bits shift in MSB first on serial clock rise; latch rise delivers the word
`timescale 1ns/10ps
module serial_word_shifter
	import regbank_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clock_in,
	input wire logic serial_control_data_in,
	input wire logic serial_latch_in,
	output logic [WORD_BITS-1:0] word_data,
	output logic word_strobe
);
	logic sclk_reg;
	logic latch_reg;
	logic [WORD_BITS-1:0] shift_reg;
	wire sclk_rise = serial_clock_in & ~sclk_reg;
	wire latch_rise = serial_latch_in & ~latch_reg;
	wire [WORD_BITS-1:0] shift_next = {shift_reg[WORD_BITS-2:0], serial_control_data_in};

	always_ff @(posedge clk) begin
		if (!rstn) begin
			sclk_reg <= 1'b0;
			latch_reg <= 1'b0;
			shift_reg <= '0;
			word_data <= '0;
			word_strobe <= 1'b0;
		end else begin
			sclk_reg <= serial_clock_in;
			latch_reg <= serial_latch_in;
			if (sclk_rise) begin
				shift_reg <= shift_next;
			end
			word_strobe <= latch_rise;
			if (latch_rise) begin
				word_data <= shift_reg;
			end
		end
	end
endmodule : serial_word_shifter

// ===== dac_control_registers_attenuation.sv
// Purpose: Program register bank of a stereo DAC with double-buffered attenuation
// Assumes: Pins synchronous to clk; frame clock rise marks each input sample
// Notes: Registers are write only; their effect is seen on the control outputs
`timescale 1ns/10ps

module dac_control_registers_attenuation
	import regbank_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_clock_in,
	input wire logic serial_control_data_in,
	input wire logic serial_latch_in,
	input wire logic frame_clock_in,
	input wire logic left_sample_zero,
	input wire logic right_sample_zero,
	output logic [7:0] left_atten_code,
	output logic [7:0] right_atten_code,
	output logic [7:0] left_converter_half_db,
	output logic [7:0] right_converter_half_db,
	output logic left_converter_full_mute,
	output logic right_converter_full_mute,
	output logic soft_silence_select,
	output logic emphasis_filter_on,
	output logic low_power_select,
	output logic [2:0] format_field,
	output logic format_i2s_bit,
	output format_kind_e format_kind,
	output logic [5:0] format_word_bits,
	output logic frame_clock_polarity,
	output logic right_follows_left_volume,
	output logic phase_invert,
	output logic bit_clock_edge_invert,
	output logic zero_run_detect_enable,
	output logic infinite_zero,
	output logic sample_ignore
);
	logic [WORD_BITS-1:0] word_data;
	logic word_strobe;

	// Serial port front end: one strobe per latched 16-bit word
	serial_word_shifter serial_word_shifter_i (
		.clk(clk),
		.rstn(rstn),
		.serial_clock_in(serial_clock_in),
		.serial_control_data_in(serial_control_data_in),
		.serial_latch_in(serial_latch_in),
		.word_data(word_data),
		.word_strobe(word_strobe)
	);

	// Word decode
	wire [6:0] word_addr = word_data[ADDR_HI:ADDR_LO];
	wire [8:0] word_val = word_data[DATA_HI:0];
	wire wr_left = word_strobe && (word_addr == ADDR_LEFT_VOLUME);
	wire wr_right = word_strobe && (word_addr == ADDR_RIGHT_VOLUME);
	wire wr_conv = word_strobe && (word_addr == ADDR_CONVERTER_CTRL);
	wire wr_intf = word_strobe && (word_addr == ADDR_INTERFACE_CTRL);
	wire apply_cmd = (wr_left | wr_right) & word_val[BIT_APPLY_STROBE];
	wire power_down_cmd = wr_conv & word_val[BIT_LOW_POWER];

	// Sample tick from frame clock rise
	logic frame_reg;
	// Outputs load one clock after the tick so they see the freshly loaded active codes
	logic tick_late_reg;
	wire sample_tick = frame_clock_in & ~frame_reg;

	logic [7:0] left_pre_reg;
	logic [7:0] right_pre_reg;
	logic apply_pending_reg;
	logic [7:0] left_active_reg;
	logic [7:0] right_active_reg;
	logic [4:0] ignore_cnt_reg;
	logic [10:0] zero_cnt_reg;

	// Pre-latch contents including the word being written now
	wire [7:0] left_pre_next = wr_left ? word_val[7:0] : left_pre_reg;
	wire [7:0] right_pre_next = wr_right ? word_val[7:0] : right_pre_reg;
	wire apply_now = sample_tick & (apply_pending_reg | apply_cmd);
	wire [7:0] right_effective = right_follows_left_volume ? left_active_reg : right_active_reg;
	wire low_power_select_release = wr_conv & low_power_select & ~word_val[BIT_LOW_POWER];
	wire both_zero = left_sample_zero & right_sample_zero;
	wire zero_run_full = (zero_cnt_reg == ZERO_RUN_SAMPLES);

	// Attenuation register file
	always_ff @(posedge clk) begin
		if (!rstn || power_down_cmd) begin
			left_pre_reg <= ATTEN_RESET;
			right_pre_reg <= ATTEN_RESET;
			left_active_reg <= ATTEN_RESET;
			right_active_reg <= ATTEN_RESET;
			apply_pending_reg <= 1'b0;
		end else begin
			left_pre_reg <= left_pre_next;
			right_pre_reg <= right_pre_next;
			if (apply_now) begin
				left_active_reg <= left_pre_next;
				right_active_reg <= right_pre_next;
			end
			// A new command arriving on a sample tick still takes effect that tick
			apply_pending_reg <= apply_now ? 1'b0 : (apply_pending_reg | apply_cmd);
		end
	end

	// Per-sample effective attenuation and level decode
	always_ff @(posedge clk) begin
		if (!rstn) begin
			frame_reg <= 1'b0;
			tick_late_reg <= 1'b0;
			left_atten_code <= ATTEN_RESET;
			right_atten_code <= ATTEN_RESET;
			left_converter_half_db <= 8'h00;
			right_converter_half_db <= 8'h00;
			left_converter_full_mute <= 1'b0;
			right_converter_full_mute <= 1'b0;
		end else begin
			frame_reg <= frame_clock_in;
			tick_late_reg <= sample_tick;
			if (power_down_cmd) begin
				// Low power returns the outputs to defaults at once, not at the next sample
				left_atten_code <= ATTEN_RESET;
				right_atten_code <= ATTEN_RESET;
				left_converter_half_db <= 8'h00;
				right_converter_half_db <= 8'h00;
				left_converter_full_mute <= 1'b0;
				right_converter_full_mute <= 1'b0;
			end else if (tick_late_reg) begin
				left_atten_code <= left_active_reg;
				right_atten_code <= right_effective;
				left_converter_half_db <= ATTEN_CODE_TOP - left_active_reg;
				right_converter_half_db <= ATTEN_CODE_TOP - right_effective;
				left_converter_full_mute <= (left_active_reg == ATTEN_CODE_MUTE);
				right_converter_full_mute <= (right_effective == ATTEN_CODE_MUTE);
			end
		end
	end

	// Converter control word; power down clears every other setting
	always_ff @(posedge clk) begin
		if (!rstn) begin
			soft_silence_select <= CTRL_BIT_RESET;
			emphasis_filter_on <= CTRL_BIT_RESET;
			low_power_select <= CTRL_BIT_RESET;
			format_field <= FORMAT_FIELD_RESET;
		end else if (power_down_cmd) begin
			soft_silence_select <= CTRL_BIT_RESET;
			emphasis_filter_on <= CTRL_BIT_RESET;
			low_power_select <= 1'b1;
			format_field <= FORMAT_FIELD_RESET;
		end else if (wr_conv) begin
			soft_silence_select <= word_val[BIT_SOFT_SILENCE];
			emphasis_filter_on <= word_val[BIT_EMPHASIS];
			low_power_select <= word_val[BIT_LOW_POWER];
			format_field <= word_val[FORMAT_HI:FORMAT_LO];
		end
	end

	// Interface control word
	always_ff @(posedge clk) begin
		if (!rstn || power_down_cmd) begin
			format_i2s_bit <= CTRL_BIT_RESET;
			frame_clock_polarity <= CTRL_BIT_RESET;
			right_follows_left_volume <= CTRL_BIT_RESET;
			phase_invert <= CTRL_BIT_RESET;
			bit_clock_edge_invert <= CTRL_BIT_RESET;
			zero_run_detect_enable <= CTRL_BIT_RESET;
		end else if (wr_intf) begin
			format_i2s_bit <= word_val[BIT_FORMAT_I2S];
			frame_clock_polarity <= word_val[BIT_FRAME_POLARITY];
			right_follows_left_volume <= word_val[BIT_RIGHT_FOLLOWS];
			phase_invert <= word_val[BIT_PHASE_INVERT];
			bit_clock_edge_invert <= word_val[BIT_BIT_CLOCK_INVERT];
			zero_run_detect_enable <= word_val[BIT_ZERO_DETECT];
		end
	end

	// Format decode; unlisted codes fall back to 16-bit right justified
	wire [3:0] format_code = {format_field[2], format_i2s_bit, format_field[1:0]};
	format_kind_e kind_next;
	logic [5:0] bits_next;
	always_comb begin
		kind_next = FMT_RIGHT_JUSTIFIED;
		bits_next = 6'h10;
		case (format_code)
			4'h0: begin
				kind_next = FMT_RIGHT_JUSTIFIED;
				bits_next = 6'h10;
			end
			4'h1: begin
				kind_next = FMT_RIGHT_JUSTIFIED;
				bits_next = 6'h14;
			end
			4'h2: begin
				kind_next = FMT_RIGHT_JUSTIFIED;
				bits_next = 6'h18;
			end
			4'h3: begin
				kind_next = FMT_LEFT_JUSTIFIED;
				bits_next = 6'h18;
			end
			4'h4: begin
				kind_next = FMT_I2S;
				bits_next = 6'h10;
			end
			4'h5: begin
				kind_next = FMT_I2S;
				bits_next = 6'h18;
			end
			4'h6: begin
				kind_next = FMT_I2S;
				bits_next = 6'h14;
			end
			4'h7: begin
				kind_next = FMT_LEFT_JUSTIFIED;
				bits_next = 6'h14;
			end
			4'h8: begin
				kind_next = FMT_DSP;
				bits_next = 6'h10;
			end
			4'h9: begin
				kind_next = FMT_DSP;
				bits_next = 6'h14;
			end
			4'ha: begin
				kind_next = FMT_DSP;
				bits_next = 6'h18;
			end
			4'hb: begin
				kind_next = FMT_DSP;
				bits_next = 6'h20;
			end
			4'hc: begin
				kind_next = FMT_LEFT_JUSTIFIED;
				bits_next = 6'h10;
			end
			default: begin
				kind_next = FMT_RIGHT_JUSTIFIED;
				bits_next = 6'h10;
			end
		endcase
	end

	// Registered so the decoded kind settles one clock after the fields
	always_ff @(posedge clk) begin
		if (!rstn) begin
			format_kind <= FMT_RIGHT_JUSTIFIED;
			format_word_bits <= 6'h10;
		end else begin
			format_kind <= kind_next;
			format_word_bits <= bits_next;
		end
	end

	// Sample ignore window after leaving low power
	always_ff @(posedge clk) begin
		if (!rstn) begin
			ignore_cnt_reg <= 5'h00;
		end else if (low_power_select_release) begin
			ignore_cnt_reg <= IGNORE_SAMPLES;
		end else if (sample_tick && ignore_cnt_reg != 5'h00) begin
			ignore_cnt_reg <= ignore_cnt_reg - 5'h01;
		end
	end
	assign sample_ignore = (ignore_cnt_reg != 5'h00);

	// Zero-run detector with automute flag
	// Counter saturates at the run length so a long silence cannot wrap the flag off
	always_ff @(posedge clk) begin
		if (!rstn || !zero_run_detect_enable) begin
			zero_cnt_reg <= 11'h000;
			infinite_zero <= 1'b0;
		end else if (sample_tick) begin
			if (!both_zero) begin
				zero_cnt_reg <= 11'h000;
				infinite_zero <= 1'b0;
			end else if (!zero_run_full) begin
				zero_cnt_reg <= zero_cnt_reg + 11'h001;
				infinite_zero <= (zero_cnt_reg + 11'h001 == ZERO_RUN_SAMPLES);
			end
		end
	end
endmodule : dac_control_registers_attenuation

// ===== dac_ctrl_properties.sv
// Purpose: Port-level assertions for the DAC control register bank
// Assumes: One clock, synchronous active-low reset
// Notes: Bound to the design from the testbench top file
`timescale 1ns/10ps
module dac_ctrl_properties
	import regbank_pkg::*;
(
	input wire logic clk,
	input wire logic rstn,
	input wire logic serial_latch_in,
	input wire logic frame_clock_in,
	input wire logic left_sample_zero,
	input wire logic [7:0] left_atten_code,
	input wire logic [7:0] right_atten_code,
	input wire logic [7:0] left_converter_half_db,
	input wire logic left_converter_full_mute,
	input wire logic soft_silence_select,
	input wire logic emphasis_filter_on,
	input wire logic low_power_select,
	input wire logic right_follows_left_volume,
	input wire logic zero_run_detect_enable,
	input wire logic infinite_zero,
	input wire logic sample_ignore
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rstn);
	a_codes_hold: assert property ($changed(left_atten_code) |->
		$past(frame_clock_in) || $past(frame_clock_in, 2) || low_power_select)
		else $error("left code moved without a sample tick");
	a_half_db_map: assert property ($stable(left_atten_code)[*2] |->
		left_converter_half_db == 8'hff - left_atten_code)
		else $error("half dB level does not match code");
	a_full_mute_map: assert property ($stable(left_atten_code)[*2] |->
		left_converter_full_mute == (left_atten_code == 8'h00))
		else $error("full mute does not match code");
	a_right_follows: assert property (right_follows_left_volume
		&& $past(right_follows_left_volume, 3) && $changed(right_atten_code)
		|-> right_atten_code == left_atten_code)
		else $error("right code differs from left while following");
	a_low_power_clear: assert property ($rose(low_power_select) |-> ##[1:2]
		(left_atten_code == 8'hff && right_atten_code == 8'hff && !soft_silence_select
		&& !emphasis_filter_on && !zero_run_detect_enable && !right_follows_left_volume))
		else $error("low power did not clear settings");
	a_ignore_start: assert property ($fell(low_power_select) |-> ##[0:2] sample_ignore)
		else $error("no ignore window after low power release");
	a_zero_off: assert property ($fell(zero_run_detect_enable) |-> ##[0:2] !infinite_zero)
		else $error("zero flag kept with detection off");
	a_zero_break: assert property (infinite_zero && $rose(frame_clock_in)
		&& !left_sample_zero |-> ##[1:3] !infinite_zero)
		else $error("zero flag kept after nonzero sample");
	a_ctrl_after_latch: assert property ($changed(emphasis_filter_on) |->
		$past(serial_latch_in, 2) || $past(serial_latch_in, 3))
		else $error("control bit changed without a word");
endmodule : dac_ctrl_properties

// ===== host_serial_model.sv
// Purpose: Host controller shifting program words into the control port
// Assumes: Each pin level held at least two clocks
// Notes: Data line shows the inverse of its last bit outside words
`timescale 1ns/10ps
module host_serial_model (
	input wire logic clk,
	output logic serial_clock_in,
	output logic serial_control_data_in,
	output logic serial_latch_in
);
	initial begin
		serial_clock_in = 1'b0;
		serial_control_data_in = 1'b0;
		serial_latch_in = 1'b0;
	end
	task automatic send(input logic [15:0] w);
		for (int i = 15; i >= 0; i--) begin
			@(negedge clk) serial_control_data_in = w[i];
			repeat (2) @(negedge clk);
			serial_clock_in = 1'b1;
			repeat (2) @(negedge clk);
			serial_clock_in = 1'b0;
		end
		@(negedge clk) serial_latch_in = 1'b1;
		serial_control_data_in = ~w[0];
		repeat (2) @(negedge clk);
		serial_latch_in = 1'b0;
		repeat (3) @(negedge clk);
	endtask : send
endmodule : host_serial_model

// ===== tb_dac_control_registers_attenuation.sv
// Purpose: Self-checking bench for the DAC control register bank
// Assumes: Host model writes words; bench drives sample pins on falling edges
// Notes: Only mismatches and the verdict are printed
`timescale 1ns/10ps
module tb_dac_control_registers_attenuation
	import regbank_pkg::*;
;
	logic clk, rstn, frame_clock_in, left_sample_zero, right_sample_zero;
	logic serial_clock_in, serial_control_data_in, serial_latch_in;
	logic [7:0] left_atten_code, right_atten_code, left_converter_half_db;
	logic [7:0] right_converter_half_db;
	logic left_converter_full_mute, right_converter_full_mute, soft_silence_select;
	logic emphasis_filter_on, low_power_select, format_i2s_bit, frame_clock_polarity;
	logic right_follows_left_volume, phase_invert, bit_clock_edge_invert;
	logic zero_run_detect_enable, infinite_zero, sample_ignore;
	logic [2:0] format_field;
	logic [5:0] format_word_bits;
	format_kind_e format_kind;
	int n_mismatch = 0;
	int total_checks = 0;
	logic [1:0] kk [13] = '{2'h0, 2'h0, 2'h0, 2'h1, 2'h2, 2'h2, 2'h2, 2'h1, 2'h3, 2'h3,
		2'h3, 2'h3, 2'h1};
	logic [5:0] ww [13] = '{6'h10, 6'h14, 6'h18, 6'h18, 6'h10, 6'h18, 6'h14, 6'h14,
		6'h10, 6'h14, 6'h18, 6'h20, 6'h10};
	dac_control_registers_attenuation dac_control_registers_attenuation_i (.*);
	host_serial_model host_serial_model_i (.*);
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		total_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		host_serial_model_i.send({a, d});
	endtask : wr
	task automatic tick(input int n);
		repeat (n) begin
			@(negedge clk) frame_clock_in = 1'b1;
			repeat (3) @(negedge clk);
			frame_clock_in = 1'b0;
			repeat (3) @(negedge clk);
		end
	endtask : tick
	task automatic t_reset();
		chk({left_atten_code, right_atten_code}, 16'hffff);
		chk({soft_silence_select, emphasis_filter_on, low_power_select, format_field}, 16'h0000);
		chk({format_i2s_bit, frame_clock_polarity, right_follows_left_volume, phase_invert,
			bit_clock_edge_invert, zero_run_detect_enable}, 16'h0000);
		chk({infinite_zero, sample_ignore, format_kind, format_word_bits}, {4'h0, 6'h10});
	endtask : t_reset
	task automatic t_again();
		@(negedge clk) rstn = 1'b0;
		repeat (2) @(negedge clk);
		rstn = 1'b1;
		t_reset();
	endtask : t_again
	task automatic t_buffer();
		wr(ADDR_LEFT_VOLUME, 9'h080);
		wr(ADDR_RIGHT_VOLUME, 9'h040);
		tick(2);
		chk({left_atten_code, right_atten_code}, 16'hffff);
		wr(ADDR_LEFT_VOLUME, 9'h110);
		chk(left_atten_code, 8'hff);
		tick(1);
		chk({left_atten_code, right_atten_code}, 16'h1040);
		wr(ADDR_RIGHT_VOLUME, 9'h020);
		tick(2);
		chk(right_atten_code, 8'h40);
	endtask : t_buffer
	task automatic t_levels();
		wr(ADDR_RIGHT_VOLUME, 9'h001);
		wr(ADDR_LEFT_VOLUME, 9'h100);
		tick(1);
		chk({left_converter_full_mute, left_converter_half_db}, 16'h01ff);
		chk({right_converter_full_mute, right_converter_half_db}, 16'h00fe);
		wr(ADDR_LEFT_VOLUME, 9'h102);
		tick(1);
		chk(left_converter_half_db, 8'hfd);
	endtask : t_levels
	task automatic t_controls();
		wr(ADDR_CONVERTER_CTRL, 9'h003);
		wr(ADDR_INTERFACE_CTRL, 9'h136);
		wr(7'h06, 9'h000);
		chk({soft_silence_select, emphasis_filter_on}, 2'h3);
		chk({zero_run_detect_enable, bit_clock_edge_invert, phase_invert,
			right_follows_left_volume, frame_clock_polarity}, 5'h1f);
		tick(1);
		chk(right_atten_code, 8'h02);
	endtask : t_controls
	task automatic t_format();
		for (int c = 0; c < 13; c++) begin
			wr(ADDR_CONVERTER_CTRL, {3'h0, c[3], c[1:0], 3'h0});
			wr(ADDR_INTERFACE_CTRL, {8'h00, c[2]});
			chk({format_kind, format_word_bits}, {kk[c], ww[c]});
		end
	endtask : t_format
	task automatic t_low_power();
		wr(ADDR_INTERFACE_CTRL, 9'h104);
		wr(ADDR_CONVERTER_CTRL, 9'h007);
		chk({low_power_select, soft_silence_select, zero_run_detect_enable}, 3'h4);
		chk({left_atten_code, right_atten_code}, 16'hffff);
		wr(ADDR_CONVERTER_CTRL, 9'h000);
		chk({low_power_select, sample_ignore}, 2'h1);
		tick(15);
		chk(sample_ignore, 1'b1);
		tick(1);
		chk(sample_ignore, 1'b0);
	endtask : t_low_power
	task automatic t_zero();
		wr(ADDR_INTERFACE_CTRL, 9'h100);
		left_sample_zero = 1'b1;
		right_sample_zero = 1'b1;
		tick(1023);
		chk(infinite_zero, 1'b0);
		tick(1);
		chk(infinite_zero, 1'b1);
		left_sample_zero = 1'b0;
		tick(1);
		chk(infinite_zero, 1'b0);
		left_sample_zero = 1'b1;
		tick(1024);
		chk(infinite_zero, 1'b1);
		wr(ADDR_INTERFACE_CTRL, 9'h000);
		chk({infinite_zero, zero_run_detect_enable}, 2'h0);
	endtask : t_zero
	task automatic wrap_up();
		if (n_mismatch == 0 && total_checks > 0) begin
			$display("ALL TESTS PASSED");
		end else begin
			$display("TESTS FAILED");
		end
		$finish;
	endtask : wrap_up
	initial begin
		repeat (100000) @(posedge clk);
		n_mismatch++;
		wrap_up();
	end
	initial begin
		rstn = 1'b0;
		frame_clock_in = 1'b0;
		left_sample_zero = 1'b0;
		right_sample_zero = 1'b0;
		repeat (10) @(negedge clk);
		rstn = 1'b1;
		t_reset();
		t_buffer();
		t_levels();
		t_controls();
		t_again();
		t_format();
		t_low_power();
		t_zero();
		wrap_up();
	end
endmodule : tb_dac_control_registers_attenuation
bind dac_control_registers_attenuation dac_ctrl_properties dac_ctrl_properties_i (.*);
